/* File: core/acs_pkg.sv */
// Constants shared by the conversion cycle sequencer
// Assumes a 40 MHz system clock
package acs_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned POR_TIME_US     = 1000;
  localparam int unsigned POR_CYCLES      = (CLK_HZ / 1000000) * POR_TIME_US;
  localparam int unsigned CONV_CYCLES     = 2000;
  localparam int unsigned CAL_CYCLES      = 64;
  localparam int unsigned WORD_BITS       = 32;
  localparam int unsigned RESULT_BITS     = 29;
  localparam int unsigned ISCK_HALF       = 20;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam logic [5:0]  BIT_CNT_RESET   = 6'h00;
  localparam logic [31:0] SHIFT_RESET     = 32'h00000000;
  localparam logic [28:0] ACC_RESET       = 29'h00000000;
  typedef enum logic [2:0] {
    ACS_ST_POR,
    ACS_ST_CAL_OFS,
    ACS_ST_CONV,
    ACS_ST_CAL_FS,
    ACS_ST_SLEEP,
    ACS_ST_OUT
  } acs_state_t;
endpackage

/* File: core/acs_sync.sv */
// Two-flop synchroniser, one per bit
// Assumes inputs asynchronous to clk_i
`timescale 1ns/1ps
module acs_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acs_sync_t;
  acs_sync_t r_q;
  acs_sync_t r_d;
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d_i;
    r_d.s2 = r_q.s1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign q_o = r_q.s2;
endmodule

/* File: core/acs_fifo.sv */
// Small sample FIFO between the modulator sample stream and the accumulator
// Assumes one clock; the drain side may stall
`timescale 1ns/1ps
module acs_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } acs_fifo_t;
  acs_fifo_t r_q;
  acs_fifo_t r_d;
  logic      push;
  logic      pop;
  assign in_ready_o  = (r_q.cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (r_q.cnt != '0);
  assign out_data_o  = r_q.mem[r_q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_comb begin
    r_d = r_q;
    if (push) begin
      r_d.mem[r_q.wp] = in_data_i;
      r_d.wp = (r_q.wp == AW'(DEPTH - 1)) ? '0 : r_q.wp + AW'(1);
    end
    if (pop) begin
      r_d.rp = (r_q.rp == AW'(DEPTH - 1)) ? '0 : r_q.rp + AW'(1);
    end
    if (push && !pop) begin
      r_d.cnt = r_q.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      r_d.cnt = r_q.cnt - (AW+1)'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule

/* File: core/acs_seq.sv */
// Conversion cycle sequencer: convert, sleep, shift out 32 bits, repeat
// Assumes pins arrive asynchronously; sample stream is on CLK_I
//
// Contract
// R1: Cycle convert, sleep, output, then convert again
// R2: Enter sleep by itself when conversion ends
// R3: Stay asleep while select is high
// R4: Hold finished result unchanged while sleeping
// R5: Select low wakes device and starts output
// R6: Shifted word is the just-finished conversion
// R7: Output bit changes on serial clock fall
// R8: Output ends after 32 bits or select high
// R9: End of output starts a new conversion
// R10: Modes come only from pin timing
// R11: Offset and full-scale calibration every conversion
// R12: Hold reset while supply-fail is indicated
// R13: Supply recovery gives about 1ms reset pulse
// R14: Power-on reset clears every register
// R15: After power-on reset, start a conversion
// R16: Select high: output released, clock ignored
// R17: Select low outside output shows done flag
// R18: Clock mode latched at power-up or select fall
// R19: Select rising during output aborts, reconverts
// R20: Conversion length is a cycle parameter
// R21: Power-on reset length is a cycle parameter
`timescale 1ns/1ps
module acs_seq #(
  parameter int unsigned POR_CYCLES  = acs_pkg::POR_CYCLES,
  parameter int unsigned CONV_CYCLES = acs_pkg::CONV_CYCLES,
  parameter int unsigned CAL_CYCLES  = acs_pkg::CAL_CYCLES,
  parameter int unsigned SAMPLE_W    = 16,
  parameter int unsigned FIFO_DEPTH  = acs_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RESET_I,
  // Supply monitor
  input  wire logic                SUPPLY_FAIL_I,
  // Serial pins
  input  wire logic                CS_N_I,
  input  wire logic                SCK_I,
  output logic                     SCK_O,
  output logic                     SCK_OE_O,
  output logic                     SERIAL_DATA_OUT_O,
  output logic                     SERIAL_DATA_OUT_OE_O,
  input  wire logic                RATE_SELECT_IN_I,
  // Modulator sample stream
  input  wire logic                SAMPLE_VALID_I,
  output logic                     SAMPLE_READY_O,
  input  wire logic [SAMPLE_W-1:0] SAMPLE_DATA_I,
  // Status
  output logic                     CONVERTING_O,
  output logic                     RATE_SELECT_O
);
  localparam int unsigned CW = 24;
  localparam int unsigned PW = (POR_CYCLES > 1) ? $clog2(POR_CYCLES + 1) : 1;

  typedef struct packed {
    acs_pkg::acs_state_t st;
    logic [CW-1:0]       cnt;
    logic [PW-1:0]       por_cnt;
    logic [5:0]          bits;
    logic [31:0]         shreg;
    logic [28:0]         acc;
    logic [28:0]         ofs;
    logic                eoc_n;
    logic                int_sck_mode;
    logic                sck_prev;
    logic                cs_prev;
    logic                isck;
    logic [7:0]          idiv;
    logic                rate;
  } acs_seq_t;

  acs_seq_t              r_q;
  acs_seq_t              r_d;
  logic                  cs_n_s;
  logic                  cs_s;
  logic                  core_rst;
  logic                  fifo_rst;
  logic                  sck_s;
  logic                  rate_s;
  logic                  sfail_s;
  logic                  smp_valid;
  logic                  smp_ready;
  logic [SAMPLE_W-1:0]   smp_data;
  logic                  fall;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  accepting;

  // Select, clock, rate and supply-fail pins pass two flops first
  // Select enters inverted, so a cleared synchroniser reads as deselected
  acs_sync #(
    .W (4)
  ) u_sync (
    .clk_i (CLK_I),
    .rst_i (RESET_I),
    .d_i   ({!CS_N_I, SCK_I, RATE_SELECT_IN_I, SUPPLY_FAIL_I}),
    .q_o   ({cs_s, sck_s, rate_s, sfail_s})
  );

  // Sample buffer stalls the modulator in the full-scale, sleep and output states; during power-on reset it is held empty
  acs_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (fifo_rst),
    .in_valid_i  (SAMPLE_VALID_I),
    .in_ready_o  (SAMPLE_READY_O),
    .in_data_i   (SAMPLE_DATA_I),
    .out_valid_o (smp_valid),
    .out_ready_i (smp_ready),
    .out_data_o  (smp_data)
  );

  assign accepting = (r_q.st == acs_pkg::ACS_ST_CONV) || (r_q.st == acs_pkg::ACS_ST_CAL_OFS);
  assign smp_ready = accepting;
  // Supply fail acts as reset; stale samples are dropped as well [R14]
  assign core_rst  = RESET_I || sfail_s;
  assign fifo_rst  = core_rst || (r_q.st == acs_pkg::ACS_ST_POR);
  assign cs_n_s    = !cs_s;
  // Serial clock edges, from the pin or from our own divider
  // Internal fall is the divider turning the clock low at this edge
  assign fall      = r_q.int_sck_mode ? (r_q.isck && r_q.idiv == 8'(acs_pkg::ISCK_HALF - 1))
                                      : (r_q.sck_prev && !sck_s);
  assign cs_fall   = r_q.cs_prev && !cs_n_s;
  assign cs_rise   = !r_q.cs_prev && cs_n_s;

  always_comb begin
    r_d          = r_q;
    r_d.sck_prev = sck_s;
    r_d.cs_prev  = cs_n_s;
    // Internal clock only toggles during output with select low
    if (r_q.st == acs_pkg::ACS_ST_OUT && r_q.int_sck_mode && !cs_n_s) begin
      if (r_q.idiv == 8'(acs_pkg::ISCK_HALF - 1)) begin
        r_d.idiv = '0;
        r_d.isck = !r_q.isck;
      end else begin
        r_d.idiv = r_q.idiv + 8'h01;
      end
    end else begin
      r_d.idiv = '0;
      r_d.isck = 1'b0;
    end
    // Mode latched at select fall, never from a register [R10] [R18]
    if (cs_fall) begin
      r_d.int_sck_mode = sck_s;
    end
    case (r_q.st)
      acs_pkg::ACS_ST_POR: begin
        r_d.eoc_n = 1'b1;
        // Power-on pulse length in clock cycles [R13] [R21]
        if (r_q.por_cnt == PW'(POR_CYCLES - 1)) begin
          r_d.st           = acs_pkg::ACS_ST_CAL_OFS;
          r_d.cnt          = '0;
          r_d.int_sck_mode = sck_s;
          r_d.rate         = rate_s;
        end else begin
          r_d.por_cnt = r_q.por_cnt + PW'(1);
        end
      end
      acs_pkg::ACS_ST_CAL_OFS: begin
        // Offset estimate taken inside each cycle, unseen by the host [R11]
        r_d.eoc_n = 1'b1;
        if (smp_valid) begin
          r_d.ofs = r_q.ofs + 29'(smp_data);
        end
        if (r_q.cnt == CW'(CAL_CYCLES - 1)) begin
          r_d.st  = acs_pkg::ACS_ST_CONV;
          r_d.cnt = '0;
          r_d.acc = acs_pkg::ACC_RESET;
        end else begin
          r_d.cnt = r_q.cnt + CW'(1);
        end
      end
      acs_pkg::ACS_ST_CONV: begin
        if (smp_valid) begin
          r_d.acc = r_q.acc + 29'(smp_data);
        end
        // Fixed conversion length [R20]
        if (r_q.cnt == CW'(CONV_CYCLES - 1)) begin
          r_d.st  = acs_pkg::ACS_ST_CAL_FS;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + CW'(1);
        end
      end
      acs_pkg::ACS_ST_CAL_FS: begin
        // Full-scale step, then load this very result [R11] [R6]
        if (r_q.cnt == CW'(CAL_CYCLES - 1)) begin
          r_d.shreg = {1'b0, 1'b0, r_q.acc - r_q.ofs, 1'b0};
          r_d.eoc_n = 1'b0;
          r_d.st    = acs_pkg::ACS_ST_SLEEP;
          r_d.cnt   = '0;
          r_d.ofs   = acs_pkg::ACC_RESET;
        end else begin
          r_d.cnt = r_q.cnt + CW'(1);
        end
      end
      acs_pkg::ACS_ST_SLEEP: begin
        // Sleep by itself and keep shreg untouched [R2] [R3] [R4]
        r_d.bits = acs_pkg::BIT_CNT_RESET;
        // Select low wakes the output [R5]
        if (!cs_n_s) begin
          r_d.st = acs_pkg::ACS_ST_OUT;
        end
      end
      acs_pkg::ACS_ST_OUT: begin
        // Abort on select high or finish at 32 bits [R8] [R19] [R9] [R1]
        if (cs_rise || cs_n_s) begin
          r_d.st    = acs_pkg::ACS_ST_CAL_OFS;
          r_d.cnt   = '0;
          r_d.eoc_n = 1'b1;
        end else if (fall) begin
          // Shift on falling edge; host samples on rising [R7]
          r_d.shreg = {r_q.shreg[30:0], 1'b0};
          r_d.bits  = r_q.bits + 6'h01;
          if (r_q.bits == 6'(acs_pkg::WORD_BITS - 1)) begin
            r_d.st    = acs_pkg::ACS_ST_CAL_OFS;
            r_d.cnt   = '0;
            r_d.eoc_n = 1'b1;
          end
        end
      end
      default: begin
        r_d.st = acs_pkg::ACS_ST_POR;
      end
    endcase
    // Rate pin may change any time; only taken in sleep and at the end of power-on reset
    if (r_q.st == acs_pkg::ACS_ST_SLEEP) begin
      r_d.rate = rate_s;
    end
  end

  always_ff @(posedge CLK_I) begin
    // Supply fail holds everything in reset; release restarts the pulse [R12] [R14] [R15]
    if (core_rst) begin
      r_q       <= '0;
      r_q.st    <= acs_pkg::ACS_ST_POR;
      r_q.eoc_n <= 1'b1;
      r_q.cs_prev  <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Output released with select high; done flag shown outside output [R16] [R17]
  always_comb begin
    SERIAL_DATA_OUT_OE_O = !cs_n_s;
    if (r_q.st == acs_pkg::ACS_ST_OUT) begin
      SERIAL_DATA_OUT_O = r_q.shreg[31];
    end else begin
      SERIAL_DATA_OUT_O = r_q.eoc_n;
    end
  end

  assign SCK_O         = r_q.isck;
  assign SCK_OE_O      = r_q.int_sck_mode && (r_q.st == acs_pkg::ACS_ST_OUT) && !cs_n_s;
  assign CONVERTING_O  = r_q.eoc_n;
  assign RATE_SELECT_O = r_q.rate;
endmodule

/* File: dv/acs_seq_sva.sv */
// Pin checker for the sequencer
// Assumes binding to acs_seq; sees its ports only
`timescale 1ns/1ps
module acs_seq_sva #(
  parameter int unsigned CONV_CYCLES = 20,
  parameter int unsigned CAL_CYCLES  = 4
) (
  // Watched pins
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic SUPPLY_FAIL_I,
  input wire logic CS_N_I,
  input wire logic SERIAL_DATA_OUT_O,
  input wire logic SERIAL_DATA_OUT_OE_O,
  input wire logic CONVERTING_O
);
  logic [15:0] run_q;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Length of the current busy stretch
  always_ff @(posedge CLK_I) begin
    run_q <= (RESET_I || !CONVERTING_O) ? 16'h0000 : run_q + 16'h0001;
  end
  sequence s_busy8;
    CONVERTING_O[*8];
  endsequence
  sequence s_desel8;
    CS_N_I[*8];
  endsequence
  property p_oe_on;
    $fell(CS_N_I) |-> ##2 SERIAL_DATA_OUT_OE_O;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_off;
    $rose(CS_N_I) |-> ##2 !SERIAL_DATA_OUT_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  // Supply fail wakes the part, so it may not count as a wake-up here
  property p_sleep_hold;
    disable iff (RESET_I || SUPPLY_FAIL_I) s_desel8 ##0 !CONVERTING_O |=> !CONVERTING_O;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep");
  property p_flag_low;
    $fell(CONVERTING_O) && SERIAL_DATA_OUT_OE_O |-> !SERIAL_DATA_OUT_O;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag high");
  property p_flag_high;
    $rose(CONVERTING_O) && SERIAL_DATA_OUT_OE_O |-> SERIAL_DATA_OUT_O;
  endproperty
  a_flag_high: assert property (p_flag_high) else $error("flag low");
  property p_conv_ends;
    $rose(CONVERTING_O) |-> s_busy8 ##[1:300] !CONVERTING_O;
  endproperty
  a_conv_ends: assert property (p_conv_ends) else $error("no sleep");
  property p_conv_len;
    $fell(CONVERTING_O) |-> run_q >= CONV_CYCLES + CAL_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("short conv");
  property p_supply;
    SUPPLY_FAIL_I[*5] |-> CONVERTING_O;
  endproperty
  a_supply: assert property (p_supply) else $error("no reset");
  property p_abort;
    $rose(CS_N_I) && SERIAL_DATA_OUT_OE_O && !CONVERTING_O |-> ##[1:6] CONVERTING_O;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
endmodule
bind acs_seq acs_seq_sva #(.CONV_CYCLES(CONV_CYCLES), .CAL_CYCLES(CAL_CYCLES)) acs_seq_sva_i (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .SUPPLY_FAIL_I(SUPPLY_FAIL_I), .CS_N_I(CS_N_I),
  .SERIAL_DATA_OUT_O(SERIAL_DATA_OUT_O), .SERIAL_DATA_OUT_OE_O(SERIAL_DATA_OUT_OE_O),
  .CONVERTING_O(CONVERTING_O));

/* File: dv/acs_host_model.sv */
// Host model reading words over select, clock and data
// Assumes the bench clock; reads in either serial clock mode
`timescale 1ns/1ps
module acs_host_model (
  // Bench clock
  input  wire logic        clk_i,
  // Serial pins
  input  wire logic        serial_data_out_i,
  input  wire logic        sck_i,
  output logic             cs_n_o,
  output logic             sck_o,
  // Result
  output logic [31:0]      word_o,
  output logic             got_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    word_o = 32'h00000000;
    got_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // Clock low at select fall picks external mode
  task automatic frame(input int n);
    cs_n_o = 1'b0;
    word_o = 32'h00000000;
    tick(8);
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b1;
      word_o = {word_o[30:0], serial_data_out_i};
      tick(4);
      sck_o = 1'b0;
      tick(4);
    end
    got_o = ~got_o;
  endtask
  // Clock high at select fall picks internal mode; pin idles high
  task automatic iframe(input int n);
    sck_o = 1'b1;
    tick(1);
    cs_n_o = 1'b0;
    word_o = 32'h00000000;
    for (int i = 0; i < n; i++) begin
      @(posedge sck_i);
      word_o = {word_o[30:0], serial_data_out_i};
    end
    // Last fall comes half a period after the last rise
    tick(24);
    got_o = ~got_o;
  endtask
  // Pulses while deselected, only when the bench asks
  task automatic stray(input int n);
    repeat (n) begin
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
      tick(4);
    end
  endtask
  task automatic deselect();
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    tick(1);
  endtask
endmodule

/* File: dv/acs_seq_tb_top.sv */
// Bench for the conversion cycle sequencer
// Assumes the host model reads in either serial clock mode
`timescale 1ns/1ps
module acs_seq_tb_top;
  localparam int POR = 20;
  localparam int CONV = 20;
  localparam int CAL = 4;
  logic clk_i, reset_i, fail_i, rate_i, valid_i, ready, take, rate_o;
  logic sck_o, sck_oe, serial_data_out, serial_data_out_oe, conv, cs_n, host_sck, got;
  logic [15:0] data;
  logic [31:0] word;
  logic [31:0] exp_q[$];
  wire sck_w = sck_oe ? sck_o : host_sck;
  wire serial_data_out_w = serial_data_out_oe ? serial_data_out : 1'bz;
  int fail_count, checked, cyc, n;
  int seed = 32'h23C3;
  acs_seq #(.POR_CYCLES(POR), .CONV_CYCLES(CONV), .CAL_CYCLES(CAL)) acs_seq_i (
    .CLK_I(clk_i), .RESET_I(reset_i), .SUPPLY_FAIL_I(fail_i), .CS_N_I(cs_n), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE_O(sck_oe), .SERIAL_DATA_OUT_O(serial_data_out),
    .SERIAL_DATA_OUT_OE_O(serial_data_out_oe),
    .RATE_SELECT_IN_I(rate_i), .SAMPLE_VALID_I(valid_i), .SAMPLE_READY_O(ready),
    .SAMPLE_DATA_I(data), .CONVERTING_O(conv), .RATE_SELECT_O(rate_o));
  acs_host_model acs_host_model_i (
    .clk_i(clk_i), .serial_data_out_i(serial_data_out_w), .sck_i(sck_w), .cs_n_o(cs_n),
    .sck_o(host_sck), .word_o(word), .got_o(got));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Offer held until taken; random gaps between samples
  always @(posedge clk_i) begin
    take = valid_i && ready;
    #2;
    if (reset_i) begin
      valid_i = 1'b0;
      data = 16'h0000;
    end else if (take || !valid_i) begin
      valid_i = 1'($random(seed));
      data = 16'($random(seed));
    end
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_word(what, {31'h0, e}, {31'h0, g});
  endtask
  task automatic gap(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  task automatic wait_conv(input logic v, input int lim);
    n = 0;
    while (conv !== v && n < lim) begin
      gap(1);
      n++;
    end
    chk_bit("converting", v, conv);
  endtask
  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Notes are masks of the status bits, which must read zero
  initial begin
    #1;
    forever begin
      @(got);
      chk_word("word", 32'h00000000, word & exp_q.pop_front());
    end
  end
  initial begin
    reset_i = 1'b1;
    fail_i = 1'b0;
    rate_i = 1'($random(seed));
    gap(12);
    reset_i = 1'b0;
    wait_conv(1'b0, 400);
    chk_bit("por", 1'b1, n >= POR + CONV);
    chk_bit("rate", rate_i, rate_o);
    for (int k = 0; k < 3; k++) begin
      // Each read starts a conversion; let it finish first
      wait_conv(1'b0, 300);
      gap(8 + ($random(seed) & 31));
      chk_bit("asleep", 1'b0, conv);
      rate_i = 1'($random(seed));
      gap(4);
      chk_bit("rate", rate_i, rate_o);
      if (k == 1) acs_host_model_i.stray(4);
      chk_bit("released", 1'b0, serial_data_out_oe);
      exp_q.push_back(32'hC0000001);
      acs_host_model_i.frame(32);
      gap(3);
      chk_bit("flag busy", 1'b1, serial_data_out_w);
      wait_conv(1'b0, 300);
      chk_bit("flag done", 1'b0, serial_data_out_w);
      exp_q.push_back(32'hC0000001);
      acs_host_model_i.frame(32);
      acs_host_model_i.deselect();
    end
    wait_conv(1'b0, 300);
    exp_q.push_back(32'h00000300);
    acs_host_model_i.frame(10);
    acs_host_model_i.deselect();
    wait_conv(1'b1, 8);
    wait_conv(1'b0, 300);
    exp_q.push_back(32'hC0000001);
    acs_host_model_i.iframe(32);
    chk_bit("int done", 1'b1, conv);
    acs_host_model_i.deselect();
    wait_conv(1'b0, 300);
    fail_i = 1'b1;
    gap(10);
    chk_bit("held", 1'b1, conv);
    fail_i = 1'b0;
    wait_conv(1'b0, 400);
    chk_bit("por", 1'b1, n >= POR + CONV);
    exp_q.push_back(32'hC0000001);
    acs_host_model_i.frame(32);
    acs_host_model_i.deselect();
    gap(4);
    chk_word("notes left", 32'h00000000, 32'(exp_q.size()));
    report_and_stop();
  end
endmodule
